// >>> hw/sasc_pkg.sv
// Constants, register map and state encoding of the step attenuator control.
// Assumes a 40 MHz system clock and an APB master on the same clock.
package sasc_pkg;

   // ****************************************************************
   // Attenuation code layout
   // ****************************************************************
   localparam int CODE_W = 6;
   localparam int BIT_16DB = 5;
   localparam int BIT_8DB = 4;
   localparam int BIT_4DB = 3;
   localparam int BIT_2DB = 2;
   localparam int BIT_1DB = 1;
   localparam int BIT_HALF_DB = 0;
   localparam logic [5:0] CODE_RESET = 6'h00;
   localparam logic [5:0] CODE_MAX = 6'h3F;

   // ****************************************************************
   // Register map, byte addresses
   // ****************************************************************
   localparam int APB_ADDR_W = 12;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_OVR_CODE = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_SHIFT = 12'h00C;
   localparam logic [11:0] OFS_LOADS = 12'h010;
   localparam int CTRL_OVR_BIT = 0;
   localparam logic CTRL_OVR_RESET = 1'b0;
   localparam int STAT_CODE_LSB = 0;
   localparam int STAT_LATCH_EN_BIT = 8;
   localparam int STAT_OPEN_BIT = 9;
   localparam int STAT_BUSY_BIT = 10;
   localparam int STAT_STABLE_BIT = 11;
   localparam int LOADS_W = 16;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_MHZ = 40;
   localparam int SETTLE_TIME_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;

   // ****************************************************************
   // Latch state
   // ****************************************************************
   typedef enum logic [1:0] {
      LATCH_OPEN = 2'b01,
      LATCH_HOLD = 2'b10
   } sasc_latch_state_t;

endpackage

// >>> hw/sasc_sync.sv
// Two-flop level synchroniser, parameterised in width.
// Assumes each bit is quasi-static or checked for stability by the reader.
`timescale 1ns/1ps
module sasc_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta <= '0;
         q_o <= '0;
      end
      else
      begin
         meta <= d_i;
         q_o <= meta;
      end
   end

endmodule

// >>> hw/sasc_top.sv
// Serial control of a six-bit step attenuator with an APB register slave.
// Assumes sclk_i is idle while rst_n_i is released and around latch_enable_i
// going high; APB runs on clk_i.
`timescale 1ns/1ps
module sasc_top
#(
   parameter int SETTLE_CYCLES = sasc_pkg::SETTLE_CYC,
   parameter int LOADS_W = sasc_pkg::LOADS_W
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic sclk_i,
   input wire logic sdata_i,
   input wire logic latch_enable_i,
   output logic atten_bit_16db_o,
   output logic atten_bit_8db_o,
   output logic atten_bit_4db_o,
   output logic atten_bit_2db_o,
   output logic atten_bit_1db_o,
   output logic atten_bit_half_db_o,
   output logic settle_busy_o
);

   localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);

   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   generate
      if (SETTLE_CYCLES < 1 || LOADS_W < 1 || LOADS_W > 32)
      begin : g_bad_param
         $error("sasc_top: unsupported parameter values");
      end
   endgenerate

   logic rst_n;
   logic latch_enable_s;
   logic [5:0] shreg;
   logic [5:0] shadow;
   logic [5:0] shadow_prev;
   logic shadow_stable;
   sasc_pkg::sasc_latch_state_t state;
   logic [5:0] latch_code;
   logic ovr_en;
   logic [5:0] ovr_code;
   logic [5:0] applied;
   logic [5:0] out_code;
   logic [SETTLE_W-1:0] settle_cnt;
   logic [LOADS_W-1:0] load_cnt;
   logic acc_ok;
   logic unmapped;
   logic [31:0] next_rdata;
   logic rd_valid;

   // ****************************************************************
   // Reset release and pin synchronisers
   // ****************************************************************
   // Reset enters asynchronously, is released through two flops
   sasc_sync #(.WIDTH(1)) u_rst_sync
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i(1'b1),
      .q_o(rst_n)
   );

   // Latch enable pin into the system domain
   // latch enable input
   sasc_sync #(.WIDTH(1)) u_latch_enable_sync
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .d_i(latch_enable_i),
      .q_o(latch_enable_s)
   );

   // ****************************************************************
   // Serial clock domain
   // ****************************************************************
   // rising edge sampling
   always_ff @(posedge sclk_i or negedge rst_n)
   begin
      if (!rst_n)
         shreg <= sasc_pkg::CODE_RESET;
      else
         shreg <= {shreg[4:0], sdata_i};
   end

   // ****************************************************************
   // Crossing of the shift register word
   // ****************************************************************
   // Word is quasi-static once the serial clock stops; a copy is only
   // trusted when two samples in a row agree, so a word caught mid-shift
   // is never passed on.
   sasc_sync #(.WIDTH(6)) u_word_sync
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .d_i(shreg),
      .q_o(shadow)
   );

   // Previous sample for the stability check
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         shadow_prev <= sasc_pkg::CODE_RESET;
      else if (ce_i)
         shadow_prev <= shadow;
   end

   assign shadow_stable = (shadow == shadow_prev);

   // ****************************************************************
   // Transparent latch
   // ****************************************************************
   // transparent while high
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         state <= sasc_pkg::LATCH_HOLD;
      else if (ce_i)
      begin
         case (state)
            sasc_pkg::LATCH_OPEN:
            begin
               if (!latch_enable_s)
                  state <= sasc_pkg::LATCH_HOLD;
            end
            sasc_pkg::LATCH_HOLD:
            begin
               if (latch_enable_s)
                  state <= sasc_pkg::LATCH_OPEN;
            end
            default:
               state <= sasc_pkg::LATCH_HOLD;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         latch_code <= sasc_pkg::CODE_RESET;
      else if (ce_i && state == sasc_pkg::LATCH_OPEN && latch_enable_s && shadow_stable)
         latch_code <= shadow;
   end

   // Count of latch closings, wraps
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         load_cnt <= '0;
      else if (ce_i && state == sasc_pkg::LATCH_OPEN && !latch_enable_s)
         load_cnt <= load_cnt + 1'b1;
   end

   // ****************************************************************
   // Attenuation outputs and settling
   // ****************************************************************
   // every code passes unchanged
   assign applied = ovr_en ? ovr_code : latch_code;

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         out_code <= sasc_pkg::CODE_RESET;
      else if (ce_i)
         out_code <= applied;
   end

   assign atten_bit_16db_o = out_code[sasc_pkg::BIT_16DB];
   assign atten_bit_8db_o = out_code[sasc_pkg::BIT_8DB];
   assign atten_bit_4db_o = out_code[sasc_pkg::BIT_4DB];
   assign atten_bit_2db_o = out_code[sasc_pkg::BIT_2DB];
   assign atten_bit_1db_o = out_code[sasc_pkg::BIT_1DB];
   assign atten_bit_half_db_o = out_code[sasc_pkg::BIT_HALF_DB];

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         settle_cnt <= '0;
      else if (ce_i)
      begin
         if (applied != out_code)
            settle_cnt <= SETTLE_W'(SETTLE_CYCLES);
         else if (settle_cnt != '0)
            settle_cnt <= settle_cnt - 1'b1;
      end
   end

   assign settle_busy_o = (settle_cnt != '0);

   // ****************************************************************
   // APB slave
   // ****************************************************************
   assign unmapped = (paddr_i[1:0] != 2'b00) ||
                     !(paddr_i == sasc_pkg::OFS_CTRL || paddr_i == sasc_pkg::OFS_OVR_CODE ||
                       paddr_i == sasc_pkg::OFS_STATUS || paddr_i == sasc_pkg::OFS_SHIFT ||
                       paddr_i == sasc_pkg::OFS_LOADS);

   // Answer only once read data is registered and the clock is enabled
   assign pready_o = psel_i & penable_i & rd_valid & ce_i;
   assign acc_ok = pready_o & pwrite_i & ~unmapped;

   // Read mux, registered during the cycle before the answer
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (paddr_i)
         sasc_pkg::OFS_CTRL:
            next_rdata[sasc_pkg::CTRL_OVR_BIT] = ovr_en;
         sasc_pkg::OFS_OVR_CODE:
            next_rdata[5:0] = ovr_code;
         sasc_pkg::OFS_STATUS:
         begin
            next_rdata[sasc_pkg::STAT_CODE_LSB +: 6] = out_code;
            next_rdata[sasc_pkg::STAT_LATCH_EN_BIT] = latch_enable_s;
            next_rdata[sasc_pkg::STAT_OPEN_BIT] = (state == sasc_pkg::LATCH_OPEN);
            next_rdata[sasc_pkg::STAT_BUSY_BIT] = settle_busy_o;
            next_rdata[sasc_pkg::STAT_STABLE_BIT] = shadow_stable;
         end
         sasc_pkg::OFS_SHIFT:
            next_rdata[5:0] = shadow;
         sasc_pkg::OFS_LOADS:
            next_rdata[LOADS_W-1:0] = load_cnt;
         default:
            next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data, error flag and answer readiness
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
         rd_valid <= 1'b0;
      end
      else if (ce_i)
      begin
         if (pready_o)
            rd_valid <= 1'b0;
         else if (psel_i && !rd_valid)
         begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
            pslverr_o <= unmapped;
            rd_valid <= 1'b1;
         end
      end
   end

   // Control and override code; read-only offsets ignore writes
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ovr_en <= sasc_pkg::CTRL_OVR_RESET;
         ovr_code <= sasc_pkg::CODE_RESET;
      end
      else if (acc_ok && pstrb_i[0])
      begin
         if (paddr_i == sasc_pkg::OFS_CTRL)
            ovr_en <= pwdata_i[sasc_pkg::CTRL_OVR_BIT];
         if (paddr_i == sasc_pkg::OFS_OVR_CODE)
            ovr_code <= pwdata_i[5:0];
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   shift_msb_a: assert property (@(posedge sclk_i) disable iff (!rst_n)
      1'b1 |=> shreg == {$past(shreg[4:0]), $past(sdata_i)})
      else $error("shift register did not shift msb first");

   shift_any_latch_a: assert property (@(posedge sclk_i) disable iff (!rst_n)
      latch_enable_i |=> shreg[0] == $past(sdata_i))
      else $error("shift blocked by latch enable");

   latch_enable_sync_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      latch_enable_s == $past(latch_enable_i, 2))
      else $error("latch enable not synchronised in two stages");

   open_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      ce_i && state == sasc_pkg::LATCH_OPEN && latch_enable_s && shadow_stable
      |=> latch_code == $past(shadow))
      else $error("open latch did not follow register");

   hold_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      state == sasc_pkg::LATCH_HOLD && !latch_enable_s
      |=> state == sasc_pkg::LATCH_HOLD && latch_code == $past(latch_code))
      else $error("held latch changed");

   close_fall_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      ce_i && state == sasc_pkg::LATCH_OPEN && !latch_enable_s
      |=> state == sasc_pkg::LATCH_HOLD ##1 latch_code == $past(latch_code))
      else $error("latch did not close on falling enable");

   bit_weight_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      ce_i && !ovr_en |=> {atten_bit_16db_o, atten_bit_8db_o, atten_bit_4db_o,
                          atten_bit_2db_o, atten_bit_1db_o, atten_bit_half_db_o}
                         == $past(latch_code))
      else $error("weighted outputs differ from latched code");

   settle_start_a: assert property (@(posedge clk_i) disable iff (!rst_n || !ce_i)
      applied != out_code |=> settle_busy_o && settle_cnt == SETTLE_W'(SETTLE_CYCLES))
      else $error("settling not flagged after change");

   apb_err_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      ce_i && psel_i && !penable_i && !rd_valid && unmapped |=> pslverr_o)
      else $error("unmapped access not flagged");

   max_code_c: cover property (@(posedge clk_i) disable iff (!rst_n)
      out_code == sasc_pkg::CODE_MAX && !ovr_en);
   close_c: cover property (@(posedge clk_i) disable iff (!rst_n)
      state == sasc_pkg::LATCH_OPEN ##1 state == sasc_pkg::LATCH_HOLD);
   ovr_c: cover property (@(posedge clk_i) disable iff (!rst_n)
      ovr_en && settle_busy_o);
   apb_wr_c: cover property (@(posedge clk_i) disable iff (!rst_n) acc_ok);

endmodule

// >>> verification/sasc_ctl_model.sv
// Behavioural controller driving the three-wire attenuator port.
// Assumes the bench calls one task at a time; link clock period is 15 ns.
`timescale 1ns/1ps
module sasc_ctl_model
(
   output logic sclk_o,
   output logic sdata_o,
   output logic latch_enable_o
);
   // ****************************************************************
   // Idle levels
   // ****************************************************************
   // Clock stands still low outside frames
   initial
   begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      latch_enable_o = 1'b0;
   end

   // ****************************************************************
   // Frame tasks
   // ****************************************************************
   // data before rising edge
   // Sends the low n bits of c, top bit first; phase offset from clk_i
   task automatic shift(input logic [5:0] c, input int n);
      int i;
      #3;
      for (i = n - 1; i >= 0; i--)
      begin
         sdata_o = c[i];
         #7.5 sclk_o = 1'b1;
         #7.5 sclk_o = 1'b0;
      end
      sdata_o = ~sdata_o; // Released data must not keep the last bit
   endtask

   task automatic pulse(input int width_ns);
      #10 latch_enable_o = 1'b1;
      #(width_ns) latch_enable_o = 1'b0;
   endtask

   // Level control for the transparent case
   task automatic set_latch_enable(input logic v);
      #10 latch_enable_o = v;
   endtask
endmodule

// >>> verification/step_attenuator_serial_control_bench.sv
// Self-checking bench of the step attenuator control: serial loads and APB.
// Assumes sasc_ctl_model as the serial controller and a 40 MHz clk_i.
`timescale 1ns/1ps
module step_attenuator_serial_control_bench;
   localparam int SETTLE = 4;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h00000000;
   logic [3:0] pstrb_i = 4'hF;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, settle_busy_o;
   logic b16, b8, b4, b2, b1, bh;
   logic sclk, sdata, latch_enable;
   logic [5:0] outs, outs_q, c, n, b;
   logic busy_q;
   logic [31:0] rd, loads;
   logic err;
   int mismatches = 0;
   int n_tests = 0;
   int seed = 32'h6457;
   int busy_run = 0;
   int i;

   assign outs = {b16, b8, b4, b2, b1, bh};

   // Clock, 25 ns period
   always #12.5 clk_i = ~clk_i;

   sasc_top #(.SETTLE_CYCLES(SETTLE)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .sclk_i(sclk), .sdata_i(sdata), .latch_enable_i(latch_enable),
      .atten_bit_16db_o(b16), .atten_bit_8db_o(b8), .atten_bit_4db_o(b4),
      .atten_bit_2db_o(b2), .atten_bit_1db_o(b1), .atten_bit_half_db_o(bh),
      .settle_busy_o(settle_busy_o));

   sasc_ctl_model ctl_u (.sclk_o(sclk), .sdata_o(sdata), .latch_enable_o(latch_enable));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   task automatic results;
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Expected register after n more bits enter at the bottom
   function automatic logic [5:0] after_shift(input logic [5:0] old, input logic [5:0] nb,
                                              input int cnt);
      after_shift = (old << cnt) | (nb & ((6'h01 << cnt) - 6'h01));
   endfunction

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (pready_o !== 1'b1 && k < 50);
      if (k >= 50)
         chk(32'h0, 32'h1, "apb hang");
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   // Full six-bit load and latch pulse of ten clk periods
   task automatic load(input logic [5:0] cc);
      @(posedge clk_i);
      ctl_u.shift(cc, 6);
      ctl_u.pulse(250);
      repeat (10) @(posedge clk_i);
   endtask

   // ****************************************************************
   // Settle flag monitor
   // ****************************************************************
   // A change of output code must raise the flag for SETTLE cycles
   always @(posedge clk_i)
   begin
      if (rst_n_i !== 1'b1)
         busy_run <= 0;
      else if (outs !== outs_q)
      begin
         chk(settle_busy_o, 1'b1, "busy on change");
         busy_run <= 1;
      end
      else if (settle_busy_o === 1'b1)
         busy_run <= busy_run + 1;
      else if (busy_q === 1'b1)
         chk(busy_run, SETTLE, "busy length");
      outs_q <= outs;
      busy_q <= settle_busy_o;
   end

   // Watchdog, far beyond the expected 60 us of traffic
   initial
   begin
      #500000;
      mismatches = mismatches + 1;
      results();
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk(outs, 6'h00, "reset code");
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0, "ctrl reset");
      apb(1'b0, 12'h008, 32'h0);
      // Both word samples are zero after reset, so the stable bit reads one
      chk(rd, 32'h1 << sasc_pkg::STAT_STABLE_BIT, "status reset");
      // Every code, zero up to full scale
      for (i = 0; i < 64; i++)
      begin
         load(i[5:0]);
         chk(outs, i[5:0], "code");
      end
      // Random codes, counting latch closes
      apb(1'b0, 12'h010, 32'h0);
      loads = rd;
      for (i = 0; i < 20; i++)
      begin
         c = 6'($random(seed));
         load(c);
         chk(outs, c, "random code");
      end
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, {16'h0, loads[15:0] + 16'd20}, "load count");
      // Shifting with latch enable low leaves the output held
      n = 6'($random(seed));
      @(posedge clk_i);
      ctl_u.shift(n, 6);
      repeat (10) @(posedge clk_i);
      chk(outs, c, "held");
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, {26'h0, n}, "shift reg");
      // Transparent latch follows a partial shift
      ctl_u.set_latch_enable(1'b1);
      repeat (10) @(posedge clk_i);
      chk(outs, n, "open");
      b = 6'($random(seed));
      ctl_u.shift(b, 3);
      repeat (10) @(posedge clk_i);
      chk(outs, after_shift(n, b, 3), "follow");
      ctl_u.set_latch_enable(1'b0);
      repeat (4) @(posedge clk_i);
      ctl_u.shift(~b, 6);
      repeat (10) @(posedge clk_i);
      chk(outs, after_shift(n, b, 3), "closed");
      // Clock enable low freezes the latch while the serial word still moves
      ce_i <= 1'b0;
      c = 6'($random(seed));
      load(c);
      chk(outs, after_shift(n, b, 3), "frozen");
      ce_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk(outs, after_shift(n, b, 3), "thawed");
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, {26'h0, c}, "shift while frozen");
      // Register bus: errors, ignored write, override path
      apb(1'b0, 12'h014, 32'h0);
      chk({rd[30:0], err}, 32'h1, "unmapped");
      apb(1'b1, 12'h002, 32'h1);
      chk({31'h0, err}, 32'h1, "misaligned");
      apb(1'b1, 12'h004, 32'h2A);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h1, "ctrl rw");
      repeat (6) @(posedge clk_i);
      chk(outs, 6'h2A, "override");
      // A write without its low strobe must leave the code alone
      pstrb_i <= 4'hE;
      apb(1'b1, 12'h004, 32'h15);
      pstrb_i <= 4'hF;
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h2A, "strobe off");
      apb(1'b1, 12'h000, 32'h0);
      c = 6'h3F;
      load(c);
      chk(outs, c, "full scale");
      results();
   end
endmodule
